/* hw/rncf_map.svh */
// register offsets, field positions, reset values and response codes of the cause flags block
// Behaviour
// R1 - watchdog nmi sets nmi cause bit 0; bit reads 0 otherwise.
// R2 - nmi pin sets nmi cause bit 1; bit reads 0 otherwise.
// R3 - reading the nmi cause word returns both flags, then clears both.
// R4 - nmi cause word is read-only, resets to zero, bits 31..2 read 0.
// R5 - reset cause word holds five flags in bits 4..0; upper bits 0; writing 0 clears.
// R6 - power-on reset sets reset cause bit 0; it reads 1 after power-up.
// R7 - reset pin sets reset cause bit 1; it also reads 1 after power-up.
// R8 - watchdog reset sets reset cause bit 2; power-up value 0.
// R9 - processor system reset request sets reset cause bit 4; power-up value 0.
// R10 - only power-on reset initialises the reset cause word; software clears it.
// R11 - debug flag is raised by the processor reset request bit.
// R12 - a cause event beats a same-cycle software clear of its flag.
`ifndef RNCF_MAP_SVH
`define RNCF_MAP_SVH

// register byte addresses
`define RNCF_NMI_ADDR 32'h400f_4018
`define RNCF_RST_ADDR 32'h400f_401c
`define RNCF_ISR_ADDR 32'h400f_4020
`define RNCF_IER_ADDR 32'h400f_4024

// field widths
`define RNCF_NMI_W 2
`define RNCF_RST_W 5
`define RNCF_EVT_W 6

// nmi cause bits
`define RNCF_NMI_WDT 0
`define RNCF_NMI_PIN 1

// reset cause bits
`define RNCF_RST_POR 0
`define RNCF_RST_PIN 1
`define RNCF_RST_WDT 2
`define RNCF_RST_BUP 3
`define RNCF_RST_DBG 4

// event status and enable bits
`define RNCF_EV_NMI_WDT 0
`define RNCF_EV_NMI_PIN 1
`define RNCF_EV_RST_PIN 2
`define RNCF_EV_RST_WDT 3
`define RNCF_EV_RST_BUP 4
`define RNCF_EV_RST_DBG 5

// decoder select bits and synchroniser lanes
`define RNCF_SEL_NMI 0
`define RNCF_SEL_RST 1
`define RNCF_SEL_ISR 2
`define RNCF_SEL_IER 3
`define RNCF_PIN_NMI 0
`define RNCF_PIN_RST 1

// reset values
`define RNCF_RST_POR_VAL 5'h03

// axi response codes
`define RNCF_RESP_OKAY 2'h0
`define RNCF_RESP_SLVERR 2'h2

`endif

/* hw/rncf_pkg.sv */
// state types of the cause flags block
`include "rncf_map.svh"
package rncf_pkg;

	// write channel states, one-hot
	typedef enum logic [1:0] {
		rncf_wr_idle = 2'b01,
		rncf_wr_resp = 2'b10
	} rncf_wr_state_t;

	// read channel states, one-hot
	typedef enum logic [1:0] {
		rncf_rd_idle = 2'b01,
		rncf_rd_data = 2'b10
	} rncf_rd_state_t;

	// every flip-flop of the top module
	typedef struct packed {
		rncf_wr_state_t wr_state;
		logic aw_have;
		logic [31:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic [1:0] bresp;
		rncf_rd_state_t rd_state;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [`RNCF_NMI_W-1:0] nmi;
		logic [`RNCF_RST_W-1:0] rst_cause;
		logic [`RNCF_EVT_W-1:0] evt_status;
		logic [`RNCF_EVT_W-1:0] evt_enable;
		logic irq;
	} rncf_state_t;

endpackage : rncf_pkg

/* hw/rncf_sync.sv */
// pin synchroniser: a change counts once the last two stages agree
`timescale 1ns/100ps
module rncf_sync #(
	parameter int WIDTH = 2,
	parameter int STAGES = 3
) (
	input wire logic aclk,
	input wire logic ce,
	input wire logic clear,
	input wire logic [WIDTH-1:0] pin_async,
	output logic [WIDTH-1:0] rise
);
	import rncf_pkg::*;

	// fewer than three stages leaves no agreement pair behind the first flop
	if (STAGES < 3)
	begin : g_stage_check
		$error("rncf_sync: STAGES must be at least 3");
	end

	typedef struct packed {
		logic [STAGES-1:0][WIDTH-1:0] chain;
		logic [WIDTH-1:0] level;
		logic [WIDTH-1:0] rise;
	} rncf_sync_state_t;

	rncf_sync_state_t q;
	rncf_sync_state_t d;
	logic [WIDTH-1:0] agree;

	// stage 0 is only ever shifted on, never compared
	for (genvar i = 0; i < WIDTH; i++)
	begin : g_agree
		assign agree[i] = q.chain[STAGES-2][i] == q.chain[STAGES-1][i];
	end

	// accepted level follows only agreeing stages; rise pulses once per accepted high
	always_comb
	begin
		d = q;
		d.chain = {q.chain[STAGES-2:0], pin_async};
		d.level = (agree & q.chain[STAGES-1]) | (~agree & q.level);
		d.rise = agree & q.chain[STAGES-1] & ~q.level;
	end

	// cleared by power-on only, so the reset pin held during system reset is still seen
	always_ff @(posedge aclk)
	begin
		if (clear)
			q <= '0;
		else if (ce)
			q <= d;
	end

	assign rise = q.rise;

endmodule : rncf_sync

/* hw/rncf_top.sv */
// axi4-lite slave holding the nmi cause and reset cause flags with an event interrupt
`timescale 1ns/100ps
`include "rncf_map.svh"
module rncf_top #(
	parameter int ADDR_W = 32
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic por_rst,
	input wire logic ce,
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_W-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire logic wdt_nmi_evt,
	input wire logic nmi_pin_async,
	input wire logic rst_pin_async,
	input wire logic wdt_rst_evt,
	input wire logic bup_rst_evt,
	input wire logic cpu_reset_request_bit,
	output logic irq
);
	import rncf_pkg::*;

	// offsets are full 32-bit addresses
	if (ADDR_W < 32)
	begin : g_addr_check
		$error("rncf_top: ADDR_W must be at least 32");
	end

	// value taken by everything on power-on
	localparam rncf_state_t RNCF_POR_STATE = '{
		wr_state: rncf_wr_idle,
		rd_state: rncf_rd_idle,
		rst_cause: `RNCF_RST_POR_VAL,
		default: '0
	};

	rncf_state_t q;
	rncf_state_t d;
	logic aw_take;
	logic w_take;
	logic ar_take;
	logic aw_now;
	logic w_now;
	logic do_write;
	logic nmi_rd_clr;
	logic [31:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic [3:0] wr_sel;
	logic [3:0] rd_sel;
	logic [1:0] pin_rise;
	logic [`RNCF_NMI_W-1:0] nmi_set;
	logic [`RNCF_RST_W-1:0] rst_set;
	logic [`RNCF_RST_W-1:0] rst_keep;
	logic [`RNCF_EVT_W-1:0] evt_set;
	logic [`RNCF_EVT_W-1:0] evt_clr;

	// word decode, shared by the write and read channels
	function automatic logic [3:0] rncf_decode(input logic [31:0] addr);
		logic [31:0] word;
		word = {addr[31:2], 2'b00};
		if (word == `RNCF_NMI_ADDR)
			rncf_decode = 4'h1;
		else if (word == `RNCF_RST_ADDR)
			rncf_decode = 4'h2;
		else if (word == `RNCF_ISR_ADDR)
			rncf_decode = 4'h4;
		else if (word == `RNCF_IER_ADDR)
			rncf_decode = 4'h8;
		else
			rncf_decode = 4'h0;
	endfunction : rncf_decode

	// external pins pass three stages before they count
	rncf_sync #(
		.WIDTH(2),
		.STAGES(3)
	) u_pin_sync (
		.aclk(aclk),
		.ce(ce),
		.clear(por_rst),
		.pin_async({rst_pin_async, nmi_pin_async}),
		.rise(pin_rise)
	);

	// readies drop in system reset and while frozen so no beat is taken unseen then; they stay up during por_rst
	assign awready = ce && aresetn && q.wr_state == rncf_wr_idle && !q.aw_have;
	assign wready = ce && aresetn && q.wr_state == rncf_wr_idle && !q.w_have;
	assign arready = ce && aresetn && q.rd_state == rncf_rd_idle;
	assign aw_take = awvalid && awready;
	assign w_take = wvalid && wready;
	assign ar_take = arvalid && arready;

	// a write goes ahead once both address and data are present, in either order
	assign aw_now = q.aw_have || aw_take;
	assign w_now = q.w_have || w_take;
	assign do_write = q.wr_state == rncf_wr_idle && aw_now && w_now;
	assign wr_addr = q.aw_have ? q.aw_addr : awaddr[31:0];
	assign wr_data = q.w_have ? q.w_data : wdata;
	assign wr_strb = q.w_have ? q.w_strb : wstrb;
	assign wr_sel = rncf_decode(wr_addr);
	assign rd_sel = rncf_decode(araddr[31:0]);

	// nmi cause sources
	always_comb
	begin
		nmi_set = '0;
		nmi_set[`RNCF_NMI_WDT] = wdt_nmi_evt; // R1
		nmi_set[`RNCF_NMI_PIN] = pin_rise[`RNCF_PIN_NMI]; // R2
	end

	// reset cause sources; power-on is the reset value itself
	always_comb
	begin
		rst_set = '0;
		rst_set[`RNCF_RST_PIN] = pin_rise[`RNCF_PIN_RST]; // R7
		rst_set[`RNCF_RST_WDT] = wdt_rst_evt; // R8
		rst_set[`RNCF_RST_BUP] = bup_rst_evt; // R5
		rst_set[`RNCF_RST_DBG] = cpu_reset_request_bit; // R9 R11
	end

	// every cause except power-on also lands in the interrupt status
	always_comb
	begin
		evt_set = '0;
		evt_set[`RNCF_EV_NMI_WDT] = nmi_set[`RNCF_NMI_WDT];
		evt_set[`RNCF_EV_NMI_PIN] = nmi_set[`RNCF_NMI_PIN];
		evt_set[`RNCF_EV_RST_PIN] = rst_set[`RNCF_RST_PIN];
		evt_set[`RNCF_EV_RST_WDT] = rst_set[`RNCF_RST_WDT];
		evt_set[`RNCF_EV_RST_BUP] = rst_set[`RNCF_RST_BUP];
		evt_set[`RNCF_EV_RST_DBG] = rst_set[`RNCF_RST_DBG];
	end

	// bus channels and flag updates
	always_comb
	begin
		d = q;
		nmi_rd_clr = 1'b0;
		rst_keep = '1;
		evt_clr = '0;

		// write channel
		case (q.wr_state)
			rncf_wr_idle:
			begin
				if (do_write)
				begin
					d.aw_have = 1'b0;
					d.w_have = 1'b0;
					d.wr_state = rncf_wr_resp;
					d.bresp = `RNCF_RESP_OKAY;
					if (wr_sel == 4'h0)
						d.bresp = `RNCF_RESP_SLVERR;
					else if (wr_strb[0])
					begin
						// nmi word ignores writes
						if (wr_sel[`RNCF_SEL_RST])
							rst_keep = wr_data[`RNCF_RST_W-1:0]; // R5
						else if (wr_sel[`RNCF_SEL_ISR])
							evt_clr = wr_data[`RNCF_EVT_W-1:0];
						else if (wr_sel[`RNCF_SEL_IER])
							d.evt_enable = wr_data[`RNCF_EVT_W-1:0];
					end
				end
				else
				begin
					if (aw_take)
					begin
						d.aw_have = 1'b1;
						d.aw_addr = awaddr[31:0];
					end
					if (w_take)
					begin
						d.w_have = 1'b1;
						d.w_data = wdata;
						d.w_strb = wstrb;
					end
				end
			end
			rncf_wr_resp:
			begin
				if (bready)
					d.wr_state = rncf_wr_idle;
			end
			default:
				d.wr_state = rncf_wr_idle;
		endcase

		// read channel; upper bits pad with zero
		case (q.rd_state)
			rncf_rd_idle:
			begin
				if (ar_take)
				begin
					d.rd_state = rncf_rd_data;
					d.rresp = `RNCF_RESP_OKAY;
					if (rd_sel[`RNCF_SEL_NMI])
					begin
						d.rdata = {{(32-`RNCF_NMI_W){1'b0}}, q.nmi}; // R4
						nmi_rd_clr = 1'b1; // R3
					end
					else if (rd_sel[`RNCF_SEL_RST])
						d.rdata = {{(32-`RNCF_RST_W){1'b0}}, q.rst_cause}; // R5
					else if (rd_sel[`RNCF_SEL_ISR])
						d.rdata = {{(32-`RNCF_EVT_W){1'b0}}, q.evt_status};
					else if (rd_sel[`RNCF_SEL_IER])
						d.rdata = {{(32-`RNCF_EVT_W){1'b0}}, q.evt_enable};
					else
					begin
						d.rdata = 32'h0;
						d.rresp = `RNCF_RESP_SLVERR;
					end
				end
			end
			rncf_rd_data:
			begin
				if (rready)
					d.rd_state = rncf_rd_idle;
			end
			default:
				d.rd_state = rncf_rd_idle;
		endcase

		// sets are applied after clears so a coincident event survives
		d.nmi = (q.nmi & ~{`RNCF_NMI_W{nmi_rd_clr}}) | nmi_set; // R3 R12
		d.rst_cause = (q.rst_cause & rst_keep) | rst_set; // R12
		d.evt_status = (q.evt_status & ~evt_clr) | evt_set;
		d.irq = |(d.evt_status & d.evt_enable);
	end

	// power-on sets everything; other resets keep the cause word and still record into it
	always_ff @(posedge aclk)
	begin
		if (por_rst)
			q <= RNCF_POR_STATE; // R6 R7 R10
		else if (!aresetn)
		begin
			q <= RNCF_POR_STATE;
			q.rst_cause <= ce ? d.rst_cause : q.rst_cause; // R10
		end
		else if (ce)
			q <= d;
	end

	assign bvalid = q.wr_state == rncf_wr_resp;
	assign bresp = q.bresp;
	assign rvalid = q.rd_state == rncf_rd_data;
	assign rdata = q.rdata;
	assign rresp = q.rresp;
	assign irq = q.irq;

	// checks, by default off during any reset or freeze
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn || por_rst || !ce);

	sequence s_nmi_read;
		ar_take && rd_sel[`RNCF_SEL_NMI];
	endsequence

	sequence s_rst_read;
		ar_take && rd_sel[`RNCF_SEL_RST];
	endsequence

	sequence s_rst_write;
		do_write && wr_sel[`RNCF_SEL_RST] && wr_strb[0];
	endsequence

	AST_NMI_WDT_SET: assert property (wdt_nmi_evt |=> q.nmi[`RNCF_NMI_WDT]) // R1
		else $error("watchdog nmi flag not set");

	AST_NMI_PIN_SET: assert property (pin_rise[`RNCF_PIN_NMI] |=> q.nmi[`RNCF_NMI_PIN]) // R2
		else $error("pin nmi flag not set");

	AST_NMI_READ_CLEARS: assert property (s_nmi_read ##0 nmi_set == '0 |=> q.nmi == '0) // R3
		else $error("nmi flags not cleared by read");

	AST_NMI_READ_DATA: assert property (s_nmi_read |=> rvalid && rdata == {30'h0, $past(q.nmi)}) // R3
		else $error("nmi read data wrong");

	AST_NMI_RO: assert property (do_write && nmi_set == '0 && !nmi_rd_clr |=> $stable(q.nmi)) // R4
		else $error("nmi word changed by write");

	AST_RST_READ_DATA: assert property (s_rst_read |=> rdata == {27'h0, $past(q.rst_cause)}) // R5
		else $error("reset cause read data wrong");

	AST_RST_WRITE_ZERO: assert property (s_rst_write ##0 rst_set == '0
		|=> q.rst_cause == ($past(q.rst_cause) & $past(wr_data[4:0]))) // R5
		else $error("reset cause write clear wrong");

	AST_POR_FLAG: assert property (disable iff (1'b0) por_rst |=> q.rst_cause[`RNCF_RST_POR]) // R6
		else $error("power-on flag not set");

	AST_POR_PIN_FLAG: assert property (disable iff (1'b0)
		por_rst |=> q.rst_cause[`RNCF_RST_PIN] && q.rst_cause[4:2] == 3'h0) // R7
		else $error("power-on value of reset cause wrong");

	AST_WDT_RST: assert property (disable iff (por_rst || !ce) wdt_rst_evt |=> q.rst_cause[`RNCF_RST_WDT]) // R8
		else $error("watchdog reset flag not set");

	AST_DBG_RST: assert property (disable iff (por_rst || !ce)
		cpu_reset_request_bit |=> q.rst_cause[`RNCF_RST_DBG]) // R9
		else $error("debug reset flag not set");

	AST_DBG_SOURCE: assert property ($rose(q.rst_cause[`RNCF_RST_DBG]) |-> $past(cpu_reset_request_bit)) // R11
		else $error("debug flag rose without reset request");

	AST_RST_HOLD: assert property (disable iff (por_rst || !ce)
		!do_write && rst_set == '0 |=> $stable(q.rst_cause)) // R10
		else $error("reset cause changed without cause or write");

	AST_SET_WINS: assert property (s_rst_write ##0 wdt_rst_evt |=> q.rst_cause[`RNCF_RST_WDT]) // R12
		else $error("reset cause lost to clear");

	AST_NMI_SET_WINS: assert property (s_nmi_read ##0 wdt_nmi_evt |=> q.nmi[`RNCF_NMI_WDT]) // R12
		else $error("nmi cause lost to read clear");

	AST_WR_RESP: assert property (do_write |=> bvalid ##0 (bresp == `RNCF_RESP_SLVERR) == $past(wr_sel == 4'h0))
		else $error("write response missing or wrong");

	AST_IRQ_LEVEL: assert property (irq == |(q.evt_status & q.evt_enable))
		else $error("irq does not follow enabled status");

endmodule : rncf_top

/* dv/tb_rncf_top.sv */
// self-checking bench for the nmi and reset cause flags block
`timescale 1ns/100ps
`include "rncf_map.svh"
module tb_rncf_top;
	import rncf_pkg::*;
	logic aclk, aresetn, por_rst, ce;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, irq;
	logic [31:0] awaddr, wdata, araddr, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic wdt_nmi_evt, nmi_pin_async, rst_pin_async, wdt_rst_evt, bup_rst_evt, cpu_reset_request_bit;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	logic [31:0] cause_exp[4] = '{32'h04, 32'h0c, 32'h1c, 32'h1e};
	int errors = 0;
	int n_compared = 0;
	localparam logic [31:0] NMI = `RNCF_NMI_ADDR;
	localparam logic [31:0] RST = `RNCF_RST_ADDR;
	localparam logic [31:0] ISR = `RNCF_ISR_ADDR;
	localparam logic [31:0] IER = `RNCF_IER_ADDR;
	localparam logic [1:0] OK = `RNCF_RESP_OKAY;
	localparam logic [1:0] ERR = `RNCF_RESP_SLVERR;

	rncf_top DUT (.aclk(aclk), .aresetn(aresetn), .por_rst(por_rst), .ce(ce), .awvalid(awvalid),
		.awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .wdt_nmi_evt(wdt_nmi_evt),
		.nmi_pin_async(nmi_pin_async), .rst_pin_async(rst_pin_async), .wdt_rst_evt(wdt_rst_evt),
		.bup_rst_evt(bup_rst_evt), .cpu_reset_request_bit(cpu_reset_request_bit), .irq(irq));

	// 125 mhz clock
	initial
	begin
		aclk = 0;
		forever #4 aclk = ~aclk;
	end

	task automatic report(input string nm, input logic [33:0] e, input logic [33:0] s);
		n_compared++;
		if (e !== s)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask : report

	task automatic chk_rd(input logic [33:0] e);
		report("read resp and data", e, {rresp, rdata});
	endtask : chk_rd

	task automatic chk_wr(input logic [1:0] e);
		report("write resp", {32'h0, e}, {32'h0, bresp});
	endtask : chk_wr

	task automatic chk_irq(input logic e);
		report("irq", {33'h0, e}, {33'h0, irq});
	endtask : chk_irq

	task automatic test_done;
		if (errors == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done

	// address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [31:0] a, input logic [31:0] dt, input logic [1:0] er);
		bit ad;
		bit wd;
		ad = 0;
		wd = 0;
		bq.push_back(er);
		awaddr <= a;
		wdata <= dt;
		wstrb <= 4'hf;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!(ad && wd))
		begin
			@(posedge aclk);
			if (awvalid && awready)
			begin
				ad = 1;
				awvalid <= 0;
			end
			if (wvalid && wready)
			begin
				wd = 1;
				wvalid <= 0;
			end
		end
		// bready stays up between writes, so it is never lowered and raised in one step
		do @(posedge aclk); while (bvalid !== 1'b1);
	endtask : axi_wr

	task automatic axi_rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
		rq.push_back({er, ed});
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 0;
		// rready stays up between reads for the same reason
		do @(posedge aclk); while (rvalid !== 1'b1);
	endtask : axi_rd

	// one-cycle pulse on a same-clock cause input
	task automatic pulse(input int k);
		case (k)
			0: wdt_nmi_evt <= 1;
			1: wdt_rst_evt <= 1;
			2: bup_rst_evt <= 1;
			default: cpu_reset_request_bit <= 1;
		endcase
		@(posedge aclk);
		{wdt_nmi_evt, wdt_rst_evt, bup_rst_evt, cpu_reset_request_bit} <= '0;
		@(posedge aclk);
		@(posedge aclk);
	endtask : pulse

	// pins pass a synchroniser, so hold them well past its depth
	task automatic pin(input bit rst_pin);
		if (rst_pin)
			rst_pin_async <= 1;
		else
			nmi_pin_async <= 1;
		repeat (8) @(posedge aclk);
		{rst_pin_async, nmi_pin_async} <= '0;
		repeat (8) @(posedge aclk);
	endtask : pin

	// result watcher: pairs each answer with the oldest note
	always @(posedge aclk)
	begin
		if (rvalid && rready)
			if (rq.size() > 0) chk_rd(rq.pop_front());
			else report("read with no note", 34'h0, 34'h1);
		if (bvalid && bready)
			if (bq.size() > 0) chk_wr(bq.pop_front());
			else report("write with no note", 34'h0, 34'h1);
	end

	// watchdog sized well beyond the sequence length
	initial
	begin
		repeat (20000) @(posedge aclk);
		errors++;
		test_done();
	end

	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{wdt_nmi_evt, nmi_pin_async, rst_pin_async, wdt_rst_evt, bup_rst_evt, cpu_reset_request_bit} = '0;
		{awaddr, wdata, araddr} = '0;
		wstrb = 4'h0;
		por_rst = 1;
		ce = 1;
		void'($urandom(86));
		repeat (12) @(posedge aclk);
		por_rst <= 0;
		aresetn <= 1;
		@(posedge aclk);
		axi_rd(RST, 32'h03, OK);
		axi_rd(NMI, 32'h0, OK);
		axi_wr(NMI, 32'hffff_ffff, OK);
		axi_rd(NMI, 32'h0, OK);
		pulse(0);
		axi_rd(NMI, 32'h1, OK);
		axi_rd(NMI, 32'h0, OK);
		pin(0);
		axi_rd(NMI, 32'h2, OK);
		pulse(0);
		pin(0);
		axi_rd(NMI, 32'h3, OK);
		axi_rd(NMI, 32'h0, OK);
		axi_wr(RST, 32'h0, OK);
		axi_rd(RST, 32'h0, OK);
		axi_wr(RST, 32'hffff_ffff, OK);
		axi_rd(RST, 32'h0, OK);
		// causes gather one by one: watchdog, backup, debug, pin
		for (int k = 0; k < 4; k++)
		begin
			if (k == 3) pin(1);
			else pulse(k + 1);
			axi_rd(RST, cause_exp[k], OK);
		end
		// a cause landing with the clearing write survives it
		wdt_rst_evt <= 1;
		fork
			axi_wr(RST, 32'h0, OK);
			begin
				@(posedge aclk);
				wdt_rst_evt <= 0;
			end
		join
		axi_rd(RST, 32'h04, OK);
		// a watchdog nmi landing with the clearing read survives it
		wdt_nmi_evt <= 1;
		fork
			axi_rd(NMI, 32'h0, OK);
			begin
				@(posedge aclk);
				wdt_nmi_evt <= 0;
			end
		join
		axi_rd(NMI, 32'h1, OK);
		pulse(0);
		aresetn <= 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		axi_rd(RST, 32'h04, OK);
		axi_rd(NMI, 32'h0, OK);
		axi_wr(IER, 32'h08, OK);
		pulse(1);
		chk_irq(1'b1);
		axi_rd(ISR, 32'h08, OK);
		axi_wr(IER, 32'h0, OK);
		chk_irq(1'b0);
		axi_wr(IER, 32'h08, OK);
		chk_irq(1'b1);
		axi_wr(ISR, 32'h08, OK);
		@(posedge aclk);
		chk_irq(1'b0);
		axi_rd(ISR, 32'h0, OK);
		axi_wr(IER + 32'h4, 32'h1, ERR);
		axi_rd(IER + 32'h4, 32'h0, ERR);
		repeat (8)
		begin
			d = $urandom;
			axi_wr(IER, d, OK);
			axi_rd(IER, {26'h0, d[5:0]}, OK);
		end
		por_rst <= 1;
		@(posedge aclk);
		por_rst <= 0;
		@(posedge aclk);
		axi_rd(RST, 32'h03, OK);
		// frozen by the clock enable, a cause is not recorded
		ce <= 0;
		pulse(1);
		ce <= 1;
		@(posedge aclk);
		axi_rd(RST, 32'h03, OK);
		repeat (3) @(posedge aclk);
		test_done();
	end
endmodule : tb_rncf_top
